// ===== byte_alu_pkg.sv
package byte_alu_pkg;
   // ****************************************
   // operand widths and ranges
   // ****************************************
   localparam int data_w = 8;
   localparam int addr_w = 7;
   localparam int file_words = 128;
   localparam int nib_lo_msb = 3;
   localparam int nib_hi_lsb = 4;

   // ****************************************
   // destination select encoding
   // ****************************************
   localparam logic dest_work = 1'b0;
   localparam logic dest_file = 1'b1;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] work_reset = 8'h00;
   localparam logic [7:0] file_reset = 8'h00;
   localparam logic flag_reset = 1'b0;

   // ****************************************
   // operation codes
   // ****************************************
   typedef enum logic [2:0] {
      op_none,
      subtract_work_from_file,
      xor_literal_into_work,
      nibble_swap_file,
      xor_work_with_file
   } alu_op_e;
endpackage

// ===== byte_alu_core.sv
module byte_alu_core (
   input wire byte_alu_pkg::alu_op_e op,
   input wire logic [7:0] work_val,
   input wire logic [7:0] file_val,
   input wire logic [7:0] literal,
   output logic [7:0] result,
   output logic carry_out,
   output logic half_carry_out,
   output logic zero_out,
   output logic carry_we,
   output logic half_carry_we,
   output logic zero_we
);
   // ****************************************
   // pure combinational operation unit
   // ****************************************
   logic [8:0] diff;
   logic [4:0] diff_lo;

   // nine-bit difference: bit 8 is the inverted borrow
   assign diff = {1'b0, file_val} + {1'b0, ~work_val} + 9'h001; // [RQ1]
   assign diff_lo = {1'b0, file_val[3:0]} + {1'b0, ~work_val[3:0]} + 5'h01; // [RQ6]

   // result and flag selection per operation
   always_comb begin
      result = file_val;
      carry_out = 1'b0;
      half_carry_out = 1'b0;
      carry_we = 1'b0;
      half_carry_we = 1'b0;
      zero_we = 1'b0;
      case (op)
         byte_alu_pkg::subtract_work_from_file: begin
            result = diff[7:0]; // [RQ1]
            carry_out = diff[8]; // [RQ6]
            half_carry_out = diff_lo[4]; // [RQ6]
            carry_we = 1'b1;
            half_carry_we = 1'b1;
            zero_we = 1'b1;
         end
         byte_alu_pkg::xor_literal_into_work: begin
            result = work_val ^ literal; // [RQ3]
            zero_we = 1'b1; // [RQ6]
         end
         byte_alu_pkg::nibble_swap_file: begin
            // swap leaves every flag alone
            result = {file_val[byte_alu_pkg::nib_lo_msb:0],
                      file_val[byte_alu_pkg::data_w-1:byte_alu_pkg::nib_hi_lsb]}; // [RQ4]
         end
         byte_alu_pkg::xor_work_with_file: begin
            result = work_val ^ file_val; // [RQ5]
            zero_we = 1'b1; // [RQ6]
         end
         default: begin
            result = file_val;
         end
      endcase
   end

   assign zero_out = (result == 8'h00); // [RQ6]
endmodule // byte_alu_core

// ===== byte_alu_sub_xor_swap.sv
// Notes on behaviour
// [RQ1] subtract: file value minus working register
// [RQ2] dest bit 0 to work, 1 to file
// [RQ3] literal xor always lands in working register
// [RQ4] swap exchanges upper and lower nibbles
// [RQ5] file xor goes to selected destination
// [RQ6] sub sets all flags; xors zero; swap none
module byte_alu_sub_xor_swap (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // operation request
   input wire logic op_valid,
   input wire byte_alu_pkg::alu_op_e op,
   input wire logic [6:0] file_addr,
   input wire logic dest_sel,
   input wire logic [7:0] literal,
   // side port to the file words
   input wire logic [6:0] rd_addr,
   input wire logic rd_en,
   input wire logic [6:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   // registered results
   output logic [7:0] rd_data,
   output logic [7:0] work_out,
   output logic carry_flag,
   output logic half_carry_flag,
   output logic zero_flag
);
   // ****************************************
   // storage
   // ****************************************
   // file words are not reset; software loads them through the side port
   logic [7:0] file_mem [byte_alu_pkg::file_words];
   // accumulator of every operation result not steered to the file
   logic [7:0] work_reg;
   // status flags
   logic carry_reg;
   logic half_carry_reg;
   logic zero_reg;
   // registered read data
   logic [7:0] rd_data_reg;

   // operation unit outputs
   logic [7:0] result;
   logic carry_out;
   logic half_carry_out;
   logic zero_out;
   logic carry_we;
   logic half_carry_we;
   logic zero_we;
   logic [7:0] file_operand;

   // decoded control
   logic exec;
   logic to_work;
   logic to_file;

   // merged write port of the file array
   logic file_wr_en;
   logic [6:0] file_wr_addr;
   logic [7:0] file_wr_data;

   // ****************************************
   // decode helpers
   // ****************************************
   // only the four real opcodes act; spare codes are harmless no-ops
   function automatic logic op_known(input byte_alu_pkg::alu_op_e code);
      logic known;
      case (code)
         byte_alu_pkg::subtract_work_from_file: known = 1'b1;
         byte_alu_pkg::xor_literal_into_work: known = 1'b1;
         byte_alu_pkg::nibble_swap_file: known = 1'b1;
         byte_alu_pkg::xor_work_with_file: known = 1'b1;
         default: known = 1'b0;
      endcase
      return known;
   endfunction

   // an operation runs only with the strobe up and a real opcode
   function automatic logic op_active(input logic valid, input byte_alu_pkg::alu_op_e code);
      return valid && op_known(code);
   endfunction

   // the literal xor has no file operand, so no destination bit either
   function automatic logic op_has_dest(input byte_alu_pkg::alu_op_e code);
      return op_known(code) && (code != byte_alu_pkg::xor_literal_into_work);
   endfunction

   // result returns to the file only for a running op with destination one
   function automatic logic op_writes_file(input logic active, input byte_alu_pkg::alu_op_e code, input logic dest);
      return active && op_has_dest(code) && (dest == byte_alu_pkg::dest_file);
   endfunction

   // a flag keeps its value unless the running op owns it
   function automatic logic flag_update(input logic active, input logic owns, input logic cur, input logic fresh);
      logic nxt;
      nxt = cur;
      if (active && owns) begin
         nxt = fresh;
      end
      return nxt;
   endfunction

   // ****************************************
   // operation unit
   // ****************************************
   // addressed word is read without a register so an op takes one cycle
   assign file_operand = file_mem[file_addr];

   byte_alu_core u_core (
      .op(op),
      .work_val(work_reg),
      .file_val(file_operand),
      .literal(literal),
      .result(result),
      .carry_out(carry_out),
      .half_carry_out(half_carry_out),
      .zero_out(zero_out),
      .carry_we(carry_we),
      .half_carry_we(half_carry_we),
      .zero_we(zero_we)
   );

   // ****************************************
   // destination steering
   // ****************************************
   // strobe qualified by a known opcode
   assign exec = op_active(op_valid, op);
   // literal xor ignores the destination bit
   assign to_file = op_writes_file(exec, op, dest_sel); // [RQ2] [RQ3]
   assign to_work = exec && !to_file; // [RQ2]

   // ****************************************
   // working register
   // ****************************************
   // takes every result that is not steered to the file
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         work_reg <= byte_alu_pkg::work_reset;
      end else if (to_work) begin
         work_reg <= result; // [RQ2] [RQ3]
      end
   end

   // ****************************************
   // file write arbitration
   // ****************************************
   // one write port: an op result beats a side-port load,
   // so a colliding load can never undo an instruction result
   always_comb begin
      file_wr_en = wr_en;
      file_wr_addr = wr_addr;
      file_wr_data = wr_data;
      if (to_file) begin
         file_wr_en = 1'b1;
         file_wr_addr = file_addr; // [RQ2]
         file_wr_data = result;
      end
   end

   // ****************************************
   // file words
   // ****************************************
   // plain array, no reset, one write a cycle
   always_ff @(posedge clock) begin
      if (file_wr_en) begin
         file_mem[file_wr_addr] <= file_wr_data;
      end
   end

   // ****************************************
   // status flags
   // ****************************************
   // carry is the inverted borrow of the subtraction
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         carry_reg <= byte_alu_pkg::flag_reset;
      end else begin
         carry_reg <= flag_update(exec, carry_we, carry_reg, carry_out); // [RQ6]
      end
   end

   // half carry is the inverted borrow out of the low nibble
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         half_carry_reg <= byte_alu_pkg::flag_reset;
      end else begin
         half_carry_reg <= flag_update(exec, half_carry_we, half_carry_reg, half_carry_out); // [RQ6]
      end
   end

   // zero follows subtract and both xors, never the swap
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         zero_reg <= byte_alu_pkg::flag_reset;
      end else begin
         zero_reg <= flag_update(exec, zero_we, zero_reg, zero_out); // [RQ6]
      end
   end

   // ****************************************
   // read port
   // ****************************************
   // data one cycle after the strobe, held otherwise
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rd_data_reg <= byte_alu_pkg::file_reset;
      end else if (rd_en) begin
         rd_data_reg <= file_mem[rd_addr];
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // every output straight from a flip-flop
   assign rd_data = rd_data_reg;
   assign work_out = work_reg;
   assign carry_flag = carry_reg;
   assign half_carry_flag = half_carry_reg;
   assign zero_flag = zero_reg;
endmodule // byte_alu_sub_xor_swap

// ===== alu_watch_monitor.sv
// ***
// port checks on the alu top
// ***
module alu_watch (
   input wire logic clock,
   input wire logic resetn,
   input wire logic op_valid,
   input wire byte_alu_pkg::alu_op_e op,
   input wire logic dest_sel,
   input wire logic [7:0] literal,
   input wire logic [7:0] work_out,
   input wire logic carry_flag,
   input wire logic half_carry_flag,
   input wire logic zero_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // decoded ops; file values are not visible here, so the bench checks them
   wire logic lx = op_valid && op == byte_alu_pkg::xor_literal_into_work;
   wire logic sb = op_valid && op == byte_alu_pkg::subtract_work_from_file;
   wire logic sw = op_valid && op == byte_alu_pkg::nibble_swap_file;
   wire logic xf = op_valid && op == byte_alu_pkg::xor_work_with_file;
   a_lit_xor_work: assert property (lx |=> work_out == ($past(work_out) ^ $past(literal)))
      else $error("literal xor wrong");
   a_file_dest_hold: assert property ((sb || sw || xf) && dest_sel |=> $stable(work_out))
      else $error("work changed");
   a_swap_no_flags: assert property (sw |=> $stable({carry_flag, half_carry_flag, zero_flag}))
      else $error("swap moved flags");
   a_xor_keep_carry: assert property (lx || xf |=> $stable({carry_flag, half_carry_flag}))
      else $error("xor moved carry");
   a_sub_zero_work: assert property (sb && !dest_sel |=> zero_flag == (work_out == 8'h00))
      else $error("sub zero wrong");
   a_xor_zero_work: assert property (xf && !dest_sel |=> zero_flag == (work_out == 8'h00))
      else $error("xor zero wrong");
   c_lit: cover property (lx);
   c_swap_file: cover property (sw && dest_sel);
   c_sub_work: cover property (sb && !dest_sel);
endmodule // alu_watch
bind byte_alu_sub_xor_swap alu_watch u_watch (.*);

// ===== tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ***
   // stimulus and model state
   // ***
   logic clock = 1'b0, resetn = 1'b0, op_valid = 1'b0, dest_sel = 1'b0, rd_en = 1'b0, wr_en = 1'b0, v, d;
   byte_alu_pkg::alu_op_e op = byte_alu_pkg::op_none, o;
   logic [6:0] file_addr = 7'h00, rd_addr = 7'h00, wr_addr = 7'h00, a;
   logic [7:0] literal = 8'h00, wr_data = 8'h00, rd_data, work_out, wm, k, fm [128];
   logic carry_flag, half_carry_flag, zero_flag;
   logic [2:0] flm;
   logic we;
   logic [6:0] wa;
   logic [7:0] wd;
   logic [10:0] e;
   logic [31:0] s = 32'h53dd;
   int fail_count = 0, checks = 0;
   always #2 clock = ~clock;
   byte_alu_sub_xor_swap dut (.*);
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // expected {result, carry, half carry, zero}
   function automatic logic [10:0] calc(byte_alu_pkg::alu_op_e p, logic [7:0] w, f, l, logic [2:0] fl);
      logic [7:0] r;
      r = (p == byte_alu_pkg::xor_literal_into_work) ? w ^ l : w ^ f;
      if (p == byte_alu_pkg::nibble_swap_file) return {f[3:0], f[7:4], fl};
      if (p != byte_alu_pkg::subtract_work_from_file) return {r, fl[2:1], r == 8'h00};
      r = f - w;
      return {r, w <= f, w[3:0] <= f[3:0], r == 8'h00};
   endfunction
   task automatic chk(logic [7:0] g, logic [7:0] x);
      checks++;
      if (g !== x) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic chk_flags(logic [2:0] g, logic [2:0] x);
      checks++;
      if (g !== x) begin
         fail_count++;
         $display("[ERR] t=%0t flags got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic end_sim;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ***
   // fill the file, then random ops; first eight literals equal work to hit zero
   // ***
   initial begin
      repeat (6) @(posedge clock);
      chk(rd_data, 8'h00);
      chk(work_out, 8'h00);
      chk_flags({carry_flag, half_carry_flag, zero_flag}, 3'h0);
      resetn <= 1'b1;
      wm = 8'h00;
      flm = 3'h0;
      for (int i = 0; i < 128; i++) begin
         s = lfsr(s);
         fm[i] = s[7:0];
         wr_en <= 1'b1;
         wr_addr <= 7'(i);
         wr_data <= s[7:0];
         @(posedge clock);
      end
      wr_en <= 1'b0;
      for (int i = 0; i < 300; i++) begin
         @(posedge clock);
         s = lfsr(s);
         v = s[7:4] != 4'h0;
         o = (s[7:4] == 4'h1) ? byte_alu_pkg::op_none : byte_alu_pkg::alu_op_e'({1'b0, s[1:0]} + 3'd1);
         a = s[14:8];
         d = s[16];
         k = (i < 8) ? wm : s[31:24];
         we = s[20] & s[21];
         wa = a ^ 7'(s[19:17]);
         wd = ~s[31:24];
         op_valid <= v;
         op <= o;
         file_addr <= a;
         dest_sel <= d;
         literal <= k;
         wr_en <= we;
         wr_addr <= wa;
         wr_data <= wd;
         v = v && (o != byte_alu_pkg::op_none);
         @(posedge clock);
         op_valid <= 1'b0;
         wr_en <= 1'b0;
         rd_en <= 1'b1;
         rd_addr <= a;
         e = calc(o, wm, fm[a], k, flm);
         if (v) flm = e[2:0];
         if (v && (o == byte_alu_pkg::xor_literal_into_work || !d)) wm = e[10:3];
         else if (v) fm[a] = e[10:3];
         // a side-port load is lost when the op writes the file
         if (we && !(v && o != byte_alu_pkg::xor_literal_into_work && d)) fm[wa] = wd;
         @(posedge clock);
         rd_en <= 1'b0;
         @(negedge clock);
         chk(rd_data, fm[a]);
         chk(work_out, wm);
         chk_flags({carry_flag, half_carry_flag, zero_flag}, flm);
      end
      end_sim;
   end
   // hang guard, about five times the expected run
   initial begin
      #20000;
      fail_count++;
      end_sim;
   end
endmodule // tb_top
